// File: logic/dpwm_gen.sv
`timescale 1ns/1ns
module dpwm_gen (
   input  wire logic                                 i_clk,
   input  wire logic                                 i_rst,
   input  wire logic [dpwm_pkg::TRIM_W-1:0]          i_oscillator_trim,
   input  dpwm_pkg::dpwm_gen_cfg_t [dpwm_pkg::NUM_GEN-1:0] i_gen_cfg,
   input  dpwm_pkg::dpwm_map_cfg_t                   i_map_cfg,
   input  wire logic [dpwm_pkg::NUM_PAR_IN-1:0]      i_par_in,
   output logic      [dpwm_pkg::NUM_CH-1:0]          o_channel,
   output logic      [dpwm_pkg::NUM_GEN-1:0]         o_gen_pwm,
   output logic      [dpwm_pkg::NUM_GEN-1:0]         o_period_start,
   output logic      [dpwm_pkg::NUM_GEN*dpwm_pkg::DUTY_W-1:0] o_duty_active
);

   ////////////////////////////////////////////////////////////////////////////
   // Decoding functions

   function automatic logic [15:0] trim_inc(input logic [3:0] code);
      logic [15:0] inc;
      inc = dpwm_pkg::INC_NOM;
      case (code)
         4'h1:    inc = dpwm_pkg::INC_M372;
         4'h2:    inc = dpwm_pkg::INC_M319;
         4'h3:    inc = dpwm_pkg::INC_M269;
         4'h4:    inc = dpwm_pkg::INC_M210;
         4'h5:    inc = dpwm_pkg::INC_M155;
         4'h6:    inc = dpwm_pkg::INC_M109;
         4'h7:    inc = dpwm_pkg::INC_M058;
         4'h9:    inc = dpwm_pkg::INC_P043;
         4'ha:    inc = dpwm_pkg::INC_P089;
         4'hb:    inc = dpwm_pkg::INC_P140;
         4'hc:    inc = dpwm_pkg::INC_P195;
         4'hd:    inc = dpwm_pkg::INC_P256;
         4'he:    inc = dpwm_pkg::INC_P324;
         4'hf:    inc = dpwm_pkg::INC_P400;
         // Reserved code runs at nominal rather than stopping the clock
         default: inc = dpwm_pkg::INC_NOM;
      endcase
      return inc;
   endfunction

   function automatic logic [1:0] pre_limit(input logic [1:0] div);
      logic [1:0] lim;
      lim = dpwm_pkg::PRE_LIM_256;
      case (div)
         dpwm_pkg::DIV_1024: lim = dpwm_pkg::PRE_LIM_1024;
         dpwm_pkg::DIV_512:  lim = dpwm_pkg::PRE_LIM_512;
         default:            lim = dpwm_pkg::PRE_LIM_256;
      endcase
      return lim;
   endfunction

   // Generator first, then parallel pin, else off; one pick per channel
   function automatic logic chan_pick(input logic gen_en,
                                      input logic gen_bit,
                                      input logic par_en,
                                      input logic par_bit);
      logic pick;
      pick = 1'b0;
      if (gen_en) begin
         pick = gen_bit;
      end else if (par_en) begin
         pick = par_bit;
      end
      return pick;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Shared base oscillator

   logic [dpwm_pkg::ACC_W-1:0] acc_q;
   logic [dpwm_pkg::ACC_W-1:0] acc_d;
   logic                       base_tick_q;
   logic                       base_tick_d;
   logic [dpwm_pkg::ACC_W-1:0] osc_inc;

   // Phase accumulator carry gives a fractional-rate base tick
   assign osc_inc = trim_inc(i_oscillator_trim);
   assign {base_tick_d, acc_d} = {1'b0, acc_q} + {1'b0, osc_inc};

   // Tick spacing averages to the trimmed rate; off-nominal codes jitter by one clock, nominal is exactly 32
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         acc_q <= '0;
      end else begin
         acc_q <= acc_d;
      end
   end

   // Carry registered so every generator sees the same tick
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         base_tick_q <= 1'b0;
      end else begin
         base_tick_q <= base_tick_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Generators

   logic [dpwm_pkg::NUM_GEN-1:0] gen_pwm_q;
   logic [dpwm_pkg::NUM_GEN-1:0] period_start_q;

   genvar g;
   generate
      for (g = 0; g < dpwm_pkg::NUM_GEN; g++) begin : gen_pwm
         logic [dpwm_pkg::PRE_W-1:0]  pre_q;
         logic [dpwm_pkg::PRE_W-1:0]  pre_d;
         logic [dpwm_pkg::DUTY_W-1:0] step_q;
         logic [dpwm_pkg::DUTY_W-1:0] step_d;
         logic [dpwm_pkg::DUTY_W-1:0] duty_q;
         logic [dpwm_pkg::DUTY_W-1:0] duty_d;
         logic [dpwm_pkg::DIV_W-1:0]  div_q;
         logic [dpwm_pkg::DIV_W-1:0]  div_d;
         logic                        step_tick;
         logic                        period_end;
         logic                        pwm_d;
         logic                        pwm_q;
         logic                        pst_q;

         // Step length set by the running divider; 256 steps per period
         assign step_tick  = base_tick_q && (pre_q == pre_limit(div_q));
         assign pre_d      = !base_tick_q ? pre_q :
                             (step_tick ? '0 : pre_q + 2'h1);
         assign period_end = step_tick && (step_q == dpwm_pkg::STEP_LAST);
         assign step_d     = step_tick ? step_q + 8'h01 : step_q;

         // Settings sampled only at the period boundary, so a write never
         // cuts a period short even from 0% or full on
         assign duty_d = period_end ? i_gen_cfg[g].duty_value : duty_q;
         assign div_d  = period_end ? i_gen_cfg[g].period_divider_select
                                    : div_q;

         // Strict compare: all-ones duty still leaves step 255 off
         assign pwm_d = (div_q == dpwm_pkg::DIV_FULL_ON) ? 1'b1 :
                        (step_q < duty_q);

         // Counters and latched settings in short blocks of their own
         always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
               pre_q  <= '0;
               step_q <= '0;
            end else begin
               pre_q  <= pre_d;
               step_q <= step_d;
            end
         end

         // Reset gives duty 0 and divider 00 until the first boundary
         always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
               duty_q <= dpwm_pkg::DUTY_RST;
               div_q  <= dpwm_pkg::DIV_RST;
            end else begin
               duty_q <= duty_d;
               div_q  <= div_d;
            end
         end

         // Local flops, so no two processes write one shared vector
         always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
               pwm_q <= 1'b0;
               pst_q <= 1'b0;
            end else begin
               pwm_q <= pwm_d;
               pst_q <= period_end;
            end
         end

         assign gen_pwm_q[g]      = pwm_q;
         assign period_start_q[g] = pst_q;

         assign o_duty_active[g*dpwm_pkg::DUTY_W +: dpwm_pkg::DUTY_W] = duty_q;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Channel mapping

   logic [dpwm_pkg::NUM_CH-1:0] channel_q;
   logic [dpwm_pkg::NUM_CH-1:0] channel_d;

   genvar c;
   generate
      for (c = 0; c < dpwm_pkg::NUM_CH; c++) begin : gen_ch
         logic gen_src;
         logic par_src;
         // Generator wins over the parallel input when both are enabled
         assign gen_src = gen_pwm_q[i_map_cfg.pwm_channel_map[c]];
         assign par_src = i_par_in[i_map_cfg.par_input_map[c]];
         assign channel_d[c] = chan_pick(i_map_cfg.pwm_output_enable[c], gen_src,
                                         i_map_cfg.par_input_enable[c], par_src);
      end
   endgenerate

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         channel_q <= '0;
      end else begin
         channel_q <= channel_d;
      end
   end

   assign o_channel      = channel_q;
   assign o_gen_pwm      = gen_pwm_q;
   assign o_period_start = period_start_q;

endmodule // dpwm_gen

// File: logic/dpwm_pkg.sv
package dpwm_pkg;

   // Generator, channel and parallel input counts
   localparam int unsigned NUM_GEN      = 2;
   localparam int unsigned NUM_CH       = 8;
   localparam int unsigned NUM_PAR_IN   = 2;

   // Field widths
   localparam int unsigned DUTY_W       = 8;
   localparam int unsigned DIV_W        = 2;
   localparam int unsigned TRIM_W       = 4;
   localparam int unsigned ACC_W        = 16;
   localparam int unsigned PRE_W        = 2;

   // Period divider codes
   localparam logic [1:0]  DIV_1024     = 2'h0;
   localparam logic [1:0]  DIV_512      = 2'h1;
   localparam logic [1:0]  DIV_256      = 2'h2;
   localparam logic [1:0]  DIV_FULL_ON  = 2'h3;

   // Base ticks per step, minus one, for the 1024, 512 and 256 codes; full on uses the 256 value
   localparam logic [1:0]  PRE_LIM_1024 = 2'h3;
   localparam logic [1:0]  PRE_LIM_512  = 2'h1;
   localparam logic [1:0]  PRE_LIM_256  = 2'h0;

   // Last step of a 256-step period
   localparam logic [7:0]  STEP_LAST    = 8'hff;

   // Oscillator trim codes
   localparam logic [3:0]  TRIM_RSVD    = 4'h0;
   localparam logic [3:0]  TRIM_NOM     = 4'h8;

   // Phase increments per trim code; nominal base rate is 50 MHz * 2048 / 65536
   localparam logic [15:0] INC_NOM      = 16'h0800;
   localparam logic [15:0] INC_M372     = 16'h0506;
   localparam logic [15:0] INC_M319     = 16'h0573;
   localparam logic [15:0] INC_M269     = 16'h05d9;
   localparam logic [15:0] INC_M210     = 16'h0652;
   localparam logic [15:0] INC_M155     = 16'h06c3;
   localparam logic [15:0] INC_M109     = 16'h0721;
   localparam logic [15:0] INC_M058     = 16'h0789;
   localparam logic [15:0] INC_P043     = 16'h0858;
   localparam logic [15:0] INC_P089     = 16'h08b6;
   localparam logic [15:0] INC_P140     = 16'h091f;
   localparam logic [15:0] INC_P195     = 16'h098f;
   localparam logic [15:0] INC_P256     = 16'h0a0c;
   localparam logic [15:0] INC_P324     = 16'h0a98;
   localparam logic [15:0] INC_P400     = 16'h0b33;

   // Reset values
   localparam logic [7:0]  DUTY_RST     = 8'h00;
   localparam logic [1:0]  DIV_RST      = 2'h0;

   typedef struct packed {
      logic [DIV_W-1:0]  period_divider_select;
      logic [DUTY_W-1:0] duty_value;
   } dpwm_gen_cfg_t;

   typedef struct packed {
      logic [NUM_CH-1:0] pwm_output_enable;
      logic [NUM_CH-1:0] pwm_channel_map;
      logic [NUM_CH-1:0] par_input_enable;
      logic [NUM_CH-1:0] par_input_map;
   } dpwm_map_cfg_t;

endpackage

// File: tb/dpwm_gen_asserts.sv
`timescale 1ns/1ns
module dpwm_gen_asserts (
   input wire logic                    i_clk,
   input wire logic                    i_rst,
   input dpwm_pkg::dpwm_gen_cfg_t [1:0] i_gen_cfg,
   input dpwm_pkg::dpwm_map_cfg_t      i_map_cfg,
   input wire logic [1:0]              i_par_in,
   input wire logic [7:0]              o_channel,
   input wire logic [1:0]              o_gen_pwm,
   input wire logic [1:0]              o_period_start,
   input wire logic [15:0]             o_duty_active
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   for (genvar g = 0; g < 2; g++) begin : gen_g
      chk_pulse_once:
         assert property (o_period_start[g] |=> !o_period_start[g]) else $error("long pulse");
      chk_duty_hold:
         assert property (!o_period_start[g] |-> $stable(o_duty_active[8*g+:8]))
         else $error("duty moved mid period");
      chk_start_on:
         assert property (o_period_start[g] && o_duty_active[8*g+:8] != 8'h00 |=> o_gen_pwm[g])
         else $error("off at period start");
      chk_zero_off:
         assert property (o_period_start[g] && o_duty_active[8*g+:8] == 8'h00
            && $past(i_gen_cfg[g].period_divider_select) != 2'h3 |=> !o_gen_pwm[g] [*8])
         else $error("on with zero duty");
      chk_full_on:
         assert property (o_period_start[g] && $past(i_gen_cfg[g].period_divider_select) == 2'h3
            |=> o_gen_pwm[g] [*8]) else $error("full on dropped");
   end
   // Reset guard: the first edge after release still sees reset-time inputs
   for (genvar c = 0; c < 8; c++) begin : gen_c
      chk_chan_pwm:
         assert property (!$past(i_rst) && $past(i_map_cfg.pwm_output_enable[c]) |->
            o_channel[c] == $past(o_gen_pwm[i_map_cfg.pwm_channel_map[c]])) else $error("pwm map");
      chk_chan_par:
         assert property (!$past(i_rst) && !$past(i_map_cfg.pwm_output_enable[c])
            && $past(i_map_cfg.par_input_enable[c]) |->
            o_channel[c] == $past(i_par_in[i_map_cfg.par_input_map[c]])) else $error("par map");
      chk_chan_idle:
         assert property (!$past(i_rst) && !$past(i_map_cfg.pwm_output_enable[c])
            && !$past(i_map_cfg.par_input_enable[c]) |-> !o_channel[c]) else $error("idle chan");
   end
endmodule // dpwm_gen_asserts
bind dpwm_gen dpwm_gen_asserts dpwm_gen_asserts_i (.i_clk(i_clk), .i_rst(i_rst),
   .i_gen_cfg(i_gen_cfg), .i_map_cfg(i_map_cfg), .i_par_in(i_par_in), .o_channel(o_channel),
   .o_gen_pwm(o_gen_pwm), .o_period_start(o_period_start), .o_duty_active(o_duty_active));

// File: tb/dpwm_load.sv
`timescale 1ns/1ns
module dpwm_load (
   input  wire logic        i_clk,
   input  wire logic        i_clear,
   input  wire logic [7:0]  i_channel,
   output logic      [15:0] o_on0,
   output logic      [15:0] o_on1
);
   // Integrates on-time like a lamp; o_on0 and o_on1 count every clock that channel 0 and channel 1 is high
   always_ff @(posedge i_clk) begin
      o_on0 <= i_clear ? 16'h0000 : o_on0 + 16'(i_channel[0]);
      o_on1 <= i_clear ? 16'h0000 : o_on1 + 16'(i_channel[1]);
   end
endmodule // dpwm_load

// File: tb/dpwm_gen_tb.sv
`timescale 1ns/1ns
module dpwm_gen_tb;
   logic                          i_clk, i_rst, clr;
   logic [3:0]                    trim;
   dpwm_pkg::dpwm_gen_cfg_t [1:0] cfg;
   dpwm_pkg::dpwm_map_cfg_t       map;
   logic [1:0]                    par, pwm, pst;
   logic [7:0]                    ch, da;
   logic [15:0]                   duty, on0, on1;
   logic [31:0]                   lfsr = 32'h8b99;
   int                            failures = 0, total_checks = 0, cyc = 0, n;
   dpwm_gen dpwm_gen_i (.i_clk(i_clk), .i_rst(i_rst), .i_oscillator_trim(trim), .i_gen_cfg(cfg),
      .i_map_cfg(map), .i_par_in(par), .o_channel(ch), .o_gen_pwm(pwm), .o_period_start(pst),
      .o_duty_active(duty));
   dpwm_load dpwm_load_i (.i_clk(i_clk), .i_clear(clr), .i_channel(ch), .o_on0(on0), .o_on1(on1));
   ////////////////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // On-time a load integrates: duty steps times clocks per step
   function automatic logic [15:0] exp_on(logic [7:0] d, int step_clk);
      return 16'(int'(d) * step_clk);
   endfunction
   task automatic chk_val(logic [15:0] got, logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_rng(int got, int lo, int hi);
      total_checks++;
      if (got < lo || got > hi) begin
         failures++;
         $display("MISMATCH %0t length %0d", $time, got);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Next setting lands mid-period, so the old duty must survive
   task automatic run_period(dpwm_pkg::dpwm_gen_cfg_t nxt, logic [7:0] old);
      n = 0;
      clr = 1'b1;
      do begin
         @(posedge i_clk);
         #2;
         n++;
         clr = 1'b0;
         lfsr = rnd(lfsr);
         par = lfsr[1:0];
         if (n == 100) cfg[0] = nxt;
         if (n == 150) chk_val(16'(duty[7:0]), 16'(old));
      end while (pst[0] !== 1'b1 && n < 40000);
      chk_val(16'(pst[0]), 16'h0001);
      chk_val(16'(duty[7:0]), 16'(nxt.duty_value));
      $display("period done, %0d cycles", n);
   endtask
   ////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 95000) begin
         failures++;
         $display("MISMATCH %0t timeout", $time);
         give_verdict();
      end
   end
   initial begin
      i_rst = 1'b1;
      clr = 1'b0;
      trim = 4'h8;
      par = 2'h0;
      cfg[0] = {2'h0, 8'h00};
      cfg[1] = {2'h3, 8'h00};
      map = {8'h0f, 8'h0a, 8'h30, 8'h20};
      repeat (4) @(posedge i_clk);
      #2 i_rst = 1'b0;
      lfsr = rnd(lfsr);
      da = lfsr[7:0];
      run_period({2'h2, da}, 8'h00);
      chk_rng(n, 32760, 32772);
      run_period({2'h2, 8'hff}, da);
      chk_rng(n, 8192, 8192);
      chk_val(on0, exp_on(da, 32));
      run_period({2'h1, 8'h00}, 8'hff);
      chk_val(on0, exp_on(8'hff, 32));
      chk_val(on1, 16'(n - 1));
      run_period({2'h2, 8'h80}, 8'h00);
      chk_rng(n, 16384, 16384);
      chk_val(on0, exp_on(8'h00, 64));
      trim = 4'hf;
      run_period({2'h2, 8'h80}, 8'h80);
      chk_rng(n, 5845, 5860);
      trim = 4'h1;
      run_period({2'h2, 8'h40}, 8'h80);
      chk_rng(n, 13035, 13050);
      give_verdict();
   end
endmodule // dpwm_gen_tb
